// ### hdl/dma_flow_pkg.sv
// constants and carriers for the bus-master dma start and flow control block
// assumes a single 50 MHz clock and a classic wishbone register port
package dma_flow_pkg;
	localparam int CLK_NS = 20;
	// register byte addresses
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_LEN = 4'h8;
	localparam logic [3:0] ADDR_WIN = 4'hC;
	// control field positions
	localparam int CTRL_GO = 0;
	localparam int CTRL_DIR_WR = 1;
	localparam int CTRL_STALL_STYLE = 2;
	localparam int CTRL_RECOVERY = 3;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [7:0] LEN_RESET = 8'h01;
	localparam logic [2:0] WIN_RESET = 3'h0;
	// timing figures in clock cycles
	localparam int IRDY_MAX_CYC = 8;
	localparam int FRAME_AFTER_STALL = 2;
	localparam int IRDY_AFTER_RDVALID = 2;
	localparam int FRAME_MAX_AFTER_GNT = 16;
	localparam logic [4:0] CNT_ZERO = 5'h00;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_REQ = 3'b001,
		ST_BEGIN = 3'b010,
		ST_WAIT = 3'b011,
		ST_FRAME = 3'b100,
		ST_DATA = 3'b101,
		ST_END = 3'b110
	} dma_state_t;

	typedef struct packed {
		logic rd_hold;
		logic wr_hold;
		logic halt;
		logic stall;
		logic rd_valid;
		logic wr_ready;
	} backend_in_t;

	typedef struct packed {
		logic frame_n;
		logic irdy_n;
		logic req_n;
	} pci_drive_t;
endpackage : dma_flow_pkg

// ### hdl/dma_start_ctrl.sv
// bus-master dma start and flow control: hold, halt and stall handling, grant loss
// assumes backend inputs synchronous to clk_i and pci pins resolved outside
`timescale 1ns/1ns
// How it works
// R1: no read starts under read hold, no write starts under write hold.
// R2: window index output names the memory region the dma is using.
// R3: backend muxes selected fifo flags onto the hold inputs by window index.
// R4: read hold release raises bus request on the next cycle.
// R5: write hold release starts the cycle with a bus request.
// R6: releasing holds starts; halt with holds stops the transfer.
// R7: frame withheld while start-delay input is high.
// R8: backend gives valid or ready within eight cycles of begin without stall.
// R9: irdy follows frame within eight cycles.
// R10: backend raises start-delay together with the begin strobe.
// R11: with style zero, frame comes two cycles after start-delay falls.
// R12: in a stalled read, irdy comes two cycles after read valid.
// R13: grant lost before frame aborts the cycle with a finish strobe.
// R14: regrant restarts and refetches, unless recovery mode keeps data.
// R15: request stays asserted after an abort until frame is driven.
// R16: backend keeps begin-to-frame delay within sixteen cycles.
// R17: frame follows grant within sixteen cycles.
// R18: halt during a burst ends it after at most two words.
// R19: held halt still starts a cycle but ends it after one word.
// R20: all backend inputs are sampled on the rising clock edge.
module dma_start_ctrl (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire dma_flow_pkg::backend_in_t be_i,
	input wire logic gnt_n_i,
	input wire logic trdy_n_i,
	output dma_flow_pkg::pci_drive_t pci_o,
	output logic initiator_engaged_o,
	output logic datapath_begin_o,
	output logic datapath_finish_o,
	output logic [2:0] window_o
);
	import dma_flow_pkg::*;

	initial begin
		if (IRDY_AFTER_RDVALID >= IRDY_MAX_CYC)
			$error("irdy spacing cannot exceed the frame-to-irdy limit");
	end

	logic [31:0] ctrl;
	logic [7:0] len;
	logic [2:0] win;
	logic done;
	dma_state_t state;
	dma_state_t next_state;
	logic [4:0] wait_cnt;
	logic [7:0] words;
	logic stalled;
	logic stall_q;
	logic rdv_q;
	logic data_kept;
	logic halted;
	logic [31:0] status;

	function automatic logic go_allowed(input logic wr, input backend_in_t b);
		go_allowed = wr ? !b.wr_hold : !b.rd_hold;
	endfunction : go_allowed

	// ----------------------------------------
	// register file
	// ----------------------------------------
	assign status = {24'h00_0000, halted, data_kept, stalled, state, 1'b0, ctrl[CTRL_GO]};

	dma_wb_regs u_regs (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.status_i(status),
		.done_i(done),
		.ctrl_o(ctrl),
		.len_o(len),
		.win_o(win)
	);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	logic wr_dir;
	logic be_ready;
	assign wr_dir = ctrl[CTRL_DIR_WR];
	assign be_ready = wr_dir ? be_i.wr_ready : be_i.rd_valid;

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (ctrl[CTRL_GO] && go_allowed(wr_dir, be_i)) // R1 R4 R5 R6 R20
					next_state = ST_REQ;
			end
			ST_REQ: begin
				if (!gnt_n_i)
					next_state = ST_BEGIN;
			end
			ST_BEGIN: next_state = ST_WAIT;
			ST_WAIT: begin
				if (gnt_n_i) // R13
					next_state = ST_REQ;
				else if (!be_i.stall && !stall_q) // R7 R11
					next_state = ST_FRAME;
			end
			ST_FRAME: next_state = ST_DATA;
			ST_DATA: begin
				if (!trdy_n_i && !pci_o.irdy_n && (words == 8'h01 || halted)) // R18 R19
					next_state = ST_END;
			end
			ST_END: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// stall sampled at begin; delay of one flop gives frame two cycles after its fall
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stall_q <= 1'b0;
			stalled <= 1'b0;
		end else begin
			stall_q <= be_i.stall; // R10 R11
			if (state == ST_BEGIN)
				stalled <= be_i.stall;
			else if (state == ST_IDLE)
				stalled <= 1'b0;
		end
	end

	// halt is sticky for the transfer so a later release cannot extend the burst
	always_ff @(posedge clk_i) begin
		if (rst_i)
			halted <= 1'b0;
		else if (state == ST_IDLE)
			halted <= 1'b0;
		else if (be_i.halt)
			halted <= 1'b1; // R6 R18
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			words <= 8'h00;
		else if (state == ST_FRAME)
			words <= len;
		else if (state == ST_DATA && !trdy_n_i && !pci_o.irdy_n && words != 8'h00)
			words <= words - 8'h01;
	end

	// recovery mode keeps data fetched before an abort; otherwise it is fetched again
	always_ff @(posedge clk_i) begin
		if (rst_i)
			data_kept <= 1'b0;
		else if (state == ST_WAIT && gnt_n_i)
			data_kept <= ctrl[CTRL_RECOVERY]; // R14
		else if (state == ST_FRAME || state == ST_IDLE)
			data_kept <= 1'b0;
	end

	// one flop puts irdy two cycles after valid, the same count as frame after the stall fall
	always_ff @(posedge clk_i) begin
		if (rst_i)
			rdv_q <= 1'b0;
		else
			rdv_q <= be_ready; // R12
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			wait_cnt <= CNT_ZERO;
		else if (state == ST_FRAME)
			wait_cnt <= CNT_ZERO;
		else if (state == ST_DATA && pci_o.irdy_n)
			wait_cnt <= wait_cnt + 5'h01;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pci_o <= '{frame_n: 1'b1, irdy_n: 1'b1, req_n: 1'b1};
			datapath_begin_o <= 1'b0;
			datapath_finish_o <= 1'b0;
			initiator_engaged_o <= 1'b0;
			window_o <= WIN_RESET;
		end else begin
			pci_o.req_n <= !(next_state == ST_REQ || next_state == ST_BEGIN || next_state == ST_WAIT); // R4 R5 R15
			pci_o.frame_n <= !(next_state == ST_FRAME || (next_state == ST_DATA && !(halted && !pci_o.irdy_n)));
			// in a stalled transfer irdy held until backend valid or ready has been seen, or forced at the limit
			if (state == ST_FRAME || state == ST_DATA)
				pci_o.irdy_n <= !(rdv_q || !stalled || wait_cnt >= 5'(IRDY_MAX_CYC - 2)) // R9 R12
				                || next_state == ST_END || next_state == ST_IDLE;
			else
				pci_o.irdy_n <= 1'b1;
			datapath_begin_o <= next_state == ST_BEGIN && !data_kept;
			datapath_finish_o <= (state == ST_WAIT && gnt_n_i) || next_state == ST_END; // R13
			initiator_engaged_o <= next_state != ST_IDLE;
			window_o <= win; // R2
		end
	end

	assign done = state == ST_END;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_stall_fall;
		state == ST_WAIT && stall_q && !be_i.stall && !gnt_n_i;
	endsequence

	chk_hold_read: assert property (@(posedge clk_i) disable iff (rst_i) // R1
		state == ST_IDLE && !wr_dir && be_i.rd_hold |=> state != ST_REQ)
		else $error("read started under hold");
	chk_hold_write: assert property (@(posedge clk_i) disable iff (rst_i) // R1
		state == ST_IDLE && wr_dir && be_i.wr_hold |=> pci_o.req_n)
		else $error("write started under hold");
	chk_req_next: assert property (@(posedge clk_i) disable iff (rst_i) // R4
		state == ST_IDLE && ctrl[CTRL_GO] && !wr_dir && !be_i.rd_hold |=> !pci_o.req_n)
		else $error("request not raised after hold release");
	chk_window_follow: assert property (@(posedge clk_i) disable iff (rst_i) // R2
		##1 window_o == $past(win))
		else $error("window index stale");
	chk_frame_stall: assert property (@(posedge clk_i) disable iff (rst_i) // R7
		state == ST_WAIT && be_i.stall |=> pci_o.frame_n)
		else $error("frame during stall");
	chk_frame_two: assert property (@(posedge clk_i) disable iff (rst_i) // R11
		s_stall_fall |=> ##1 (!pci_o.frame_n || datapath_finish_o))
		else $error("frame not two cycles after stall fall");
	chk_irdy_bound: assert property (@(posedge clk_i) disable iff (rst_i) // R9
		$fell(pci_o.frame_n) |-> ##[0:8] !pci_o.irdy_n)
		else $error("irdy late after frame");
	chk_abort_finish: assert property (@(posedge clk_i) disable iff (rst_i) // R13
		state == ST_WAIT && gnt_n_i |=> datapath_finish_o && !pci_o.req_n)
		else $error("abort without finish or request");
	chk_frame_grant: assert property (@(posedge clk_i) disable iff (rst_i) // R17
		state == ST_BEGIN && !be_i.stall |-> ##[1:16] (!pci_o.frame_n || state == ST_REQ))
		else $error("frame late after grant");
	chk_halt_end: assert property (@(posedge clk_i) disable iff (rst_i) // R18 R19
		state == ST_DATA && halted && !trdy_n_i && !pci_o.irdy_n |=> state == ST_END)
		else $error("burst not ended after halt");

	sequence s_valid_seen;
		stalled && !wr_dir && be_ready && pci_o.irdy_n;
	endsequence

	sequence s_phase_idle;
		(state == ST_FRAME || state == ST_DATA) && pci_o.irdy_n;
	endsequence

	chk_irdy_valid: assert property (@(posedge clk_i) disable iff (rst_i) // R12
		s_valid_seen ##1 s_phase_idle |=> !pci_o.irdy_n)
		else $error("irdy not two cycles after read valid");
	chk_req_retry: assert property (@(posedge clk_i) disable iff (rst_i) // R15
		(state == ST_REQ || state == ST_BEGIN || state == ST_WAIT) |=> (!pci_o.req_n || !pci_o.frame_n))
		else $error("request dropped before frame");
	chk_finish_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // R13
		datapath_finish_o |=> !datapath_finish_o)
		else $error("finish strobe longer than one cycle");
	chk_refetch_begin: assert property (@(posedge clk_i) disable iff (rst_i) // R14
		state == ST_REQ && !gnt_n_i && !ctrl[CTRL_RECOVERY] |=> datapath_begin_o)
		else $error("no refetch after regrant");
endmodule : dma_start_ctrl

// ### hdl/dma_wb_regs.sv
// wishbone classic register slave for the dma flow control block
// assumes a synchronous active-high reset and word-aligned accesses
`timescale 1ns/1ns
module dma_wb_regs (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [31:0] status_i,
	input wire logic done_i,
	output logic [31:0] ctrl_o,
	output logic [7:0] len_o,
	output logic [2:0] win_o
);
	import dma_flow_pkg::*;

	logic hit;
	assign hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= hit;
	end

	// go is cleared by hardware when the transfer ends; a software set in the same cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_o <= CTRL_RESET;
			len_o <= LEN_RESET;
			win_o <= WIN_RESET;
		end else begin
			if (done_i)
				ctrl_o[CTRL_GO] <= 1'b0;
			if (hit && wb_we_i && wb_sel_i[0]) begin
				case (wb_adr_i)
					ADDR_CTRL: ctrl_o[7:0] <= wb_dat_i[7:0];
					ADDR_LEN: len_o <= wb_dat_i[7:0];
					ADDR_WIN: win_o <= wb_dat_i[2:0];
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (hit && !wb_we_i) begin
			case (wb_adr_i)
				ADDR_CTRL: wb_dat_o <= ctrl_o;
				ADDR_STATUS: wb_dat_o <= status_i;
				ADDR_LEN: wb_dat_o <= {24'h00_0000, len_o};
				ADDR_WIN: wb_dat_o <= {29'h0000_0000, win_o};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end
endmodule : dma_wb_regs

// ### tb/dma_far_model.sv
// far side model: backend fifo control, pci arbiter and pci target
// assumes the block's pci drive lines and begin strobe on one clock
`timescale 1ns/1ns
module dma_far_model
	import dma_flow_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire dma_flow_pkg::pci_drive_t pci_i,
	input wire logic begin_i,
	input wire logic rd_hold_i,
	input wire logic wr_hold_i,
	input wire logic halt_i,
	input wire logic [3:0] stall_len_i,
	input wire logic deny_i,
	output logic gnt_n_o,
	output logic trdy_n_o,
	output dma_flow_pkg::backend_in_t be_o
);
	logic [3:0] stall_cnt;
	logic stall;
	logic [1:0] stall_hist;
	logic ready;
	// stall rises with the begin strobe and lasts stall_len_i cycles
	assign stall = (stall_len_i != 4'h0) && (begin_i || stall_cnt != 4'h0);
	// valid and ready trail a stall by two cycles so irdy timing shows apart from frame
	assign ready = !stall && stall_hist == 2'b00;
	assign be_o = {rd_hold_i, wr_hold_i, halt_i, stall, ready, ready};
	always_ff @(posedge clk_i) begin
		if (rst_i)
			stall_hist <= 2'b00;
		else
			stall_hist <= {stall_hist[0], stall};
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stall_cnt <= 4'h0;
		end else if (begin_i && stall_len_i != 4'h0) begin
			stall_cnt <= stall_len_i - 4'h1;
		end else if (stall_cnt != 4'h0) begin
			stall_cnt <= stall_cnt - 4'h1;
		end
	end
	// deny stands for a higher-priority master taking the grant away
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gnt_n_o <= 1'b1;
			trdy_n_o <= 1'b1;
		end else begin
			gnt_n_o <= pci_i.req_n | deny_i;
			trdy_n_o <= pci_i.frame_n & pci_i.irdy_n;
		end
	end
endmodule : dma_far_model

// ### tb/dma_master_start_flow_control_tb.sv
// self-checking bench for the dma start and flow control block
// assumes the far side model answers grant, target ready and backend lines
`timescale 1ns/1ns
module dma_master_start_flow_control_tb;
	import dma_flow_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, rdh = 1'b0, wrh = 1'b0, halt = 1'b0, deny = 1'b0;
	logic [3:0] adr = 4'h0, slen = 4'h0;
	logic [31:0] dat = 32'h0, rd, q;
	logic gnt_n, trdy_n, eng, dbeg, dfin, ack, ps, pg, ph, pv;
	logic [2:0] win;
	backend_in_t be;
	pci_drive_t pci, prev;
	int n_mismatch = 0, total_checks = 0, cn = 0, t_req, t_frm, t_irdy, t_st, t_gnt, t_rel;
	int n_w = 0, n_fin = 0, n_beg = 0, w0, f0, b0, tf, t_val;
	always #10 clk_i = ~clk_i;
	dma_start_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack), .be_i(be),
		.gnt_n_i(gnt_n), .trdy_n_i(trdy_n), .pci_o(pci), .initiator_engaged_o(eng),
		.datapath_begin_o(dbeg), .datapath_finish_o(dfin), .window_o(win));
	dma_far_model i_far (.clk_i(clk_i), .rst_i(rst_i), .pci_i(pci), .begin_i(dbeg), .rd_hold_i(rdh),
		.wr_hold_i(wrh), .halt_i(halt), .stall_len_i(slen), .deny_i(deny), .gnt_n_o(gnt_n),
		.trdy_n_o(trdy_n), .be_o(be));
	// ------------------------------------------------------------
	// edge monitor and timeout
	// ------------------------------------------------------------
	always @(posedge clk_i) begin
		if (prev.req_n && !pci.req_n) t_req = cn;
		if (prev.frame_n && !pci.frame_n) t_frm = cn;
		if (prev.irdy_n && !pci.irdy_n) t_irdy = cn;
		if (ps && !be.stall) t_st = cn;
		if (pg && !gnt_n) t_gnt = cn;
		if (ph && !(be.rd_hold | be.wr_hold)) t_rel = cn;
		if (!pv && be.rd_valid) t_val = cn;
		if (!pci.irdy_n && !trdy_n) n_w++;
		if (dfin) n_fin++;
		if (dbeg) n_beg++;
		prev = pci;
		ps = be.stall;
		pg = gnt_n;
		ph = be.rd_hold | be.wr_hold;
		pv = be.rd_valid;
		cn++;
		if (cn == 3000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		rd = q;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic wait_fin();
		while (dfin !== 1'b1) @(posedge clk_i);
		repeat (3) @(posedge clk_i);
	endtask : wait_fin
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		check("idle drive", 32'h7, {29'h0, pci});
		wb(1'b0, ADDR_LEN, 32'h0);
		check("len reset", {24'h0, LEN_RESET}, rd);
		wb(1'b0, 4'h2, 32'h0);
		check("unmapped", 32'h0, rd);
		wb(1'b1, ADDR_WIN, 32'h5);
		check("window", 32'h5, {29'h0, win});
		for (int d = 0; d < 2; d++) begin
			rdh <= (d == 0);
			wrh <= (d == 1);
			w0 = n_w;
			wb(1'b1, ADDR_CTRL, 32'(1 + 2 * d));
			repeat (6) @(posedge clk_i);
			check("held req", 32'h1, {31'h0, pci.req_n});
			check("engaged idle", 32'h0, {31'h0, eng});
			rdh <= 1'b0;
			wrh <= 1'b0;
			wait_fin();
			check("req after release", 32'h1, 32'(t_req - t_rel));
			check("words", 32'h1, 32'(n_w - w0));
			wb(1'b0, ADDR_CTRL, 32'h0);
			check("go cleared", 32'(2 * d), rd);
		end
		slen <= 4'h5;
		wb(1'b1, ADDR_CTRL, 32'h1);
		wait_fin();
		check("frame after stall", 32'h2, 32'(t_frm - t_st));
		check("irdy after valid", 32'h2, 32'(t_irdy - t_val));
		check("frame after grant", 32'h1, 32'(t_frm - t_gnt <= FRAME_MAX_AFTER_GNT));
		check("irdy after frame", 32'h1, 32'(t_irdy - t_frm <= IRDY_MAX_CYC));
		for (int r = 0; r < 2; r++) begin
			slen <= 4'h8;
			b0 = n_beg;
			f0 = n_fin;
			tf = t_frm;
			wb(1'b1, ADDR_CTRL, 32'(1 + 8 * r));
			while (dbeg !== 1'b1) @(posedge clk_i);
			deny <= 1'b1;
			wait_fin();
			check("no frame on abort", 32'(tf), 32'(t_frm));
			check("abort finish", 32'h1, 32'(n_fin - f0));
			check("req kept", 32'h0, {31'h0, pci.req_n});
			check("engaged retry", 32'h1, {31'h0, eng});
			slen <= 4'h0;
			deny <= 1'b0;
			wait_fin();
			check("refetch", 32'(2 - r), 32'(n_beg - b0));
			check("frame after regrant", 32'h1, 32'(t_frm != tf));
		end
		halt <= 1'b1;
		wb(1'b1, ADDR_LEN, 32'h4);
		w0 = n_w;
		wb(1'b1, ADDR_CTRL, 32'h1);
		wait_fin();
		check("halt one word", 32'h1, 32'(n_w - w0));
		halt <= 1'b0;
		repeat (20) @(posedge clk_i);
		w0 = n_w;
		wb(1'b1, ADDR_CTRL, 32'h1);
		wait_fin();
		check("burst words", 32'h4, 32'(n_w - w0));
		wb(1'b1, ADDR_LEN, 32'h8);
		w0 = n_w;
		wb(1'b1, ADDR_CTRL, 32'h1);
		while (pci.irdy_n !== 1'b0 || trdy_n !== 1'b0) @(posedge clk_i);
		halt <= 1'b1;
		wait_fin();
		halt <= 1'b0;
		check("halt mid burst", 32'h1, 32'(n_w - w0 <= 3));
		summarize();
	end
endmodule : dma_master_start_flow_control_tb
